// [hw/cmd_decoder_pkg.sv]
// constants shared by the special command decoder and its shutter controllers
package cmd_decoder_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CODE_HOST_MODE    = 8'hEE;
  localparam logic [7:0] CODE_BATCH        = 8'hDF;
  localparam logic [7:0] CODE_SHUT_A_OPEN  = 8'hAA;
  localparam logic [7:0] CODE_SHUT_A_COND  = 8'hAB;
  localparam logic [7:0] CODE_SHUT_A_CLOSE = 8'hAC;
  localparam logic [7:0] CODE_SHUT_B_OPEN  = 8'hBA;
  localparam logic [7:0] CODE_SHUT_B_COND  = 8'hBB;
  localparam logic [7:0] CODE_SHUT_B_CLOSE = 8'hBC;
  localparam logic [3:0] POS_MAX           = 4'h9;
  localparam int         POS_LSB           = 0;
  localparam int         WHEEL_BIT         = 7;
  localparam logic [2:0] BATCH_LEN         = 3'h4;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_MHZ       = 250;
  localparam int          POLL_US       = 50;
  localparam int          POLL_CYCLES   = POLL_US * CLK_MHZ;
  localparam int          HOLD_US       = 1;
  localparam logic [15:0] HOLD_RESET    = 16'(HOLD_US * CLK_MHZ);

  // ****************************************
  // register map, word index on the avalon address
  // ****************************************
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_STATUS   = 3'h1;
  localparam logic [2:0] REG_LAST_CMD = 3'h2;
  localparam logic [2:0] REG_HOLD     = 3'h3;

  localparam int CTRL_POLL_EN     = 0;
  localparam int CTRL_FORCE_LOCAL = 1;
  localparam logic CTRL_POLL_EN_RESET = 1'b1;

  localparam int ST_HOST_MODE  = 0;
  localparam int ST_SRC_SERIAL = 1;
  localparam int ST_BUSY       = 2;
  localparam int ST_BATCH_LSB  = 4;
  localparam int ST_SHUT_A     = 8;
  localparam int ST_SHUT_B     = 9;

  typedef enum logic [1:0] {SH_CLOSED, SH_OPEN, SH_COND} shut_mode_t;
  typedef enum logic [2:0] {PH_IDLE, PH_COLLECT, PH_SHUT, PH_FILT_A, PH_FILT_B} phase_t;

endpackage

// [hw/shutter_ctrl.sv]
// one shutter: open, conditional open while its wheel stands, close
`timescale 1ns/1ps
module shutter_ctrl #(
  parameter logic [7:0] CODE_OPEN  = 8'h00,
  parameter logic [7:0] CODE_COND  = 8'h00,
  parameter logic [7:0] CODE_CLOSE = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       cmd_stb,
  input  wire logic [7:0] cmd_code,
  input  wire logic       wheel_moving,
  output logic            open_q
);

  cmd_decoder_pkg::shut_mode_t mode_q;
  cmd_decoder_pkg::shut_mode_t mode_d;

  always_comb begin
    mode_d = mode_q;
    if (cmd_stb) begin
      if (cmd_code == CODE_OPEN) begin
        mode_d = cmd_decoder_pkg::SH_OPEN;
      end else if (cmd_code == CODE_COND) begin
        mode_d = cmd_decoder_pkg::SH_COND;
      end else if (cmd_code == CODE_CLOSE) begin
        mode_d = cmd_decoder_pkg::SH_CLOSED;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_q <= cmd_decoder_pkg::SH_CLOSED;
      open_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      // conditional mode follows the wheel: shut while moving, open when stopped
      open_q <= (mode_d == cmd_decoder_pkg::SH_OPEN) ||
                ((mode_d == cmd_decoder_pkg::SH_COND) && !wheel_moving);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  open_cmd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_stb && cmd_code == CODE_OPEN |=> open_q)
    else $error("shutter did not open on open code");
  close_cmd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_stb && cmd_code == CODE_CLOSE |=> !open_q)
    else $error("shutter did not close on close code");
  cond_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_q == cmd_decoder_pkg::SH_COND && !cmd_stb |=> open_q == !$past(wheel_moving))
    else $error("conditional shutter does not follow wheel motion");

endmodule

// [hw/special_cmd_decoder.sv]
// special command decoder: input polling, busy handshake, host mode, batches, shutters
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module special_cmd_decoder #(
  parameter int POLL_CYCLES = cmd_decoder_pkg::POLL_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  par_cmd,
  input  wire logic        ser_stb,
  input  wire logic [7:0]  ser_cmd,
  input  wire logic        local_req,
  input  wire logic        wheel_a_moving,
  input  wire logic        wheel_b_moving,
  output logic             busy_q,
  output logic             host_mode_q,
  output logic             src_serial_q,
  output logic             shutter_a_open_q,
  output logic             shutter_b_open_q,
  output logic             filt_stb_q,
  output logic [7:0]       filt_byte_q
);

  // ****************************************
  // register bus
  // ****************************************
  logic        wait_q;
  logic        poll_en_q;
  logic [15:0] hold_cfg_q;
  logic        force_local;
  logic [7:0]  last_cmd_q;
  logic [2:0]  batch_cnt_q;
  logic [31:0] status_w;
  logic        bus_ack;

  assign avs_waitrequest = wait_q;
  assign bus_ack         = (avs_read || avs_write) && !wait_q;
  assign force_local     = bus_ack && avs_write && avs_address == cmd_decoder_pkg::REG_CTRL &&
                           avs_writedata[cmd_decoder_pkg::CTRL_FORCE_LOCAL];

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[cmd_decoder_pkg::ST_HOST_MODE]  = host_mode_q;
    status_w[cmd_decoder_pkg::ST_SRC_SERIAL] = src_serial_q;
    status_w[cmd_decoder_pkg::ST_BUSY]       = busy_q;
    status_w[cmd_decoder_pkg::ST_BATCH_LSB +: 3] = batch_cnt_q;
    status_w[cmd_decoder_pkg::ST_SHUT_A]     = shutter_a_open_q;
    status_w[cmd_decoder_pkg::ST_SHUT_B]     = shutter_b_open_q;
  end

  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_q) begin
      unique case (avs_address)
        cmd_decoder_pkg::REG_CTRL:     avs_readdata <= {31'h0, poll_en_q};
        cmd_decoder_pkg::REG_STATUS:   avs_readdata <= status_w;
        cmd_decoder_pkg::REG_LAST_CMD: avs_readdata <= {24'h0, last_cmd_q};
        cmd_decoder_pkg::REG_HOLD:     avs_readdata <= {16'h0, hold_cfg_q};
        default:                       avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      poll_en_q  <= cmd_decoder_pkg::CTRL_POLL_EN_RESET;
      hold_cfg_q <= cmd_decoder_pkg::HOLD_RESET;
    end else if (bus_ack && avs_write) begin
      if (avs_address == cmd_decoder_pkg::REG_CTRL) begin
        poll_en_q <= avs_writedata[cmd_decoder_pkg::CTRL_POLL_EN];
      end
      if (avs_address == cmd_decoder_pkg::REG_HOLD) begin
        hold_cfg_q <= avs_writedata[15:0];
      end
    end
  end

  // ****************************************
  // input polling and capture
  // ****************************************
  logic [15:0] poll_cnt_q;
  logic        poll_tick;
  logic [7:0]  prev_par_q;
  logic        par_take;
  logic        ser_pend_q;
  logic [7:0]  ser_byte_q;
  logic        ser_take;
  logic        cmd_stb_q;
  logic [7:0]  cmd_byte_q;
  logic        cmd_src_q;

  assign poll_tick = poll_cnt_q == 16'(POLL_CYCLES - 1);
  assign par_take  = poll_tick && poll_en_q && !busy_q && par_cmd != prev_par_q;
  assign ser_take  = ser_pend_q && !busy_q && !par_take;

  always_ff @(posedge core_clk) begin
    if (sys_rst || poll_tick) begin
      poll_cnt_q <= 16'h0000;
    end else begin
      poll_cnt_q <= poll_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_par_q <= 8'h00;
    end else if (poll_tick && poll_en_q && !busy_q) begin
      prev_par_q <= par_cmd;
    end
  end

  // a byte arriving as the old one is taken is kept: set wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ser_pend_q <= 1'b0;
      ser_byte_q <= 8'h00;
    end else if (ser_stb) begin
      ser_pend_q <= 1'b1;
      ser_byte_q <= ser_cmd;
    end else if (ser_take) begin
      ser_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_stb_q  <= 1'b0;
      cmd_byte_q <= 8'h00;
      cmd_src_q  <= 1'b0;
      last_cmd_q <= 8'h00;
    end else begin
      cmd_stb_q <= par_take || ser_take;
      if (par_take || ser_take) begin
        cmd_byte_q <= par_take ? par_cmd : ser_byte_q;
        cmd_src_q  <= !par_take;
        last_cmd_q <= par_take ? par_cmd : ser_byte_q;
      end
    end
  end

  // ****************************************
  // decode
  // ****************************************
  logic is_host, is_batch, is_shut_a, is_shut_b, is_filt, from_active, act;

  always_comb begin
    // host, batch and shutter codes compare the whole byte; a filter command only needs a low nibble of at most 9
    is_host   = cmd_byte_q == cmd_decoder_pkg::CODE_HOST_MODE;
    is_batch  = cmd_byte_q == cmd_decoder_pkg::CODE_BATCH;
    is_shut_a = cmd_byte_q inside {cmd_decoder_pkg::CODE_SHUT_A_OPEN,
                                   cmd_decoder_pkg::CODE_SHUT_A_COND,
                                   cmd_decoder_pkg::CODE_SHUT_A_CLOSE};
    is_shut_b = cmd_byte_q inside {cmd_decoder_pkg::CODE_SHUT_B_OPEN,
                                   cmd_decoder_pkg::CODE_SHUT_B_COND,
                                   cmd_decoder_pkg::CODE_SHUT_B_CLOSE};
    is_filt   = cmd_byte_q[cmd_decoder_pkg::POS_LSB +: 4] <= cmd_decoder_pkg::POS_MAX;
    from_active = cmd_src_q == src_serial_q;
    act       = cmd_stb_q && host_mode_q && from_active;
  end

  // ****************************************
  // host mode and source
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_mode_q  <= 1'b0;
      src_serial_q <= 1'b0;
    end else if (cmd_stb_q && is_host) begin
      host_mode_q  <= 1'b1;
      src_serial_q <= cmd_src_q;
    end else if (local_req || force_local) begin
      host_mode_q <= 1'b0;
    end
  end

  // ****************************************
  // batch collection and run
  // ****************************************
  cmd_decoder_pkg::phase_t phase_q;
  logic [7:0] slot_q [4];
  logic [3:0] slot_vld_q;
  logic [1:0] slot_idx;
  logic       slot_hit;

  always_comb begin
    // entries sort by value into fixed slots, so order does not matter
    slot_hit = 1'b1;
    slot_idx = 2'd0;
    if (is_shut_a) begin
      slot_idx = 2'd0;
    end else if (is_shut_b) begin
      slot_idx = 2'd1;
    end else if (is_filt) begin
      slot_idx = cmd_byte_q[cmd_decoder_pkg::WHEEL_BIT] ? 2'd3 : 2'd2;
    end else begin
      slot_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_q     <= cmd_decoder_pkg::PH_IDLE;
      batch_cnt_q <= 3'h0;
      slot_vld_q  <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        slot_q[i] <= 8'h00;
      end
    end else begin
      unique case (phase_q)
        cmd_decoder_pkg::PH_IDLE: begin
          if (act && is_batch) begin
            phase_q     <= cmd_decoder_pkg::PH_COLLECT;
            batch_cnt_q <= 3'h0;
            slot_vld_q  <= 4'h0;
          end
        end
        cmd_decoder_pkg::PH_COLLECT: begin
          if (act && slot_hit) begin
            slot_q[slot_idx]     <= cmd_byte_q;
            slot_vld_q[slot_idx] <= 1'b1;
            batch_cnt_q          <= batch_cnt_q + 3'h1;
            if (batch_cnt_q == cmd_decoder_pkg::BATCH_LEN - 3'h1) begin
              phase_q <= cmd_decoder_pkg::PH_SHUT;
            end
          end
        end
        cmd_decoder_pkg::PH_SHUT:   phase_q <= cmd_decoder_pkg::PH_FILT_A;
        cmd_decoder_pkg::PH_FILT_A: phase_q <= cmd_decoder_pkg::PH_FILT_B;
        cmd_decoder_pkg::PH_FILT_B: begin
          phase_q     <= cmd_decoder_pkg::PH_IDLE;
          batch_cnt_q <= 3'h0;
        end
        default: phase_q <= cmd_decoder_pkg::PH_IDLE;
      endcase
    end
  end

  // ****************************************
  // shutter and filter dispatch
  // ****************************************
  logic       single;
  logic       sh_a_stb, sh_b_stb;
  logic [7:0] sh_a_code, sh_b_code;
  logic       run_shut;

  assign single   = act && phase_q == cmd_decoder_pkg::PH_IDLE;
  assign run_shut = phase_q == cmd_decoder_pkg::PH_SHUT;

  always_comb begin
    sh_a_stb  = (single && is_shut_a) || (run_shut && slot_vld_q[0]);
    sh_b_stb  = (single && is_shut_b) || (run_shut && slot_vld_q[1]);
    sh_a_code = run_shut ? slot_q[0] : cmd_byte_q;
    sh_b_code = run_shut ? slot_q[1] : cmd_byte_q;
  end

  shutter_ctrl #(
    .CODE_OPEN  (cmd_decoder_pkg::CODE_SHUT_A_OPEN),
    .CODE_COND  (cmd_decoder_pkg::CODE_SHUT_A_COND),
    .CODE_CLOSE (cmd_decoder_pkg::CODE_SHUT_A_CLOSE)
  ) u_shut_a (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .cmd_stb      (sh_a_stb),
    .cmd_code     (sh_a_code),
    .wheel_moving (wheel_a_moving),
    .open_q       (shutter_a_open_q)
  );

  shutter_ctrl #(
    .CODE_OPEN  (cmd_decoder_pkg::CODE_SHUT_B_OPEN),
    .CODE_COND  (cmd_decoder_pkg::CODE_SHUT_B_COND),
    .CODE_CLOSE (cmd_decoder_pkg::CODE_SHUT_B_CLOSE)
  ) u_shut_b (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .cmd_stb      (sh_b_stb),
    .cmd_code     (sh_b_code),
    .wheel_moving (wheel_b_moving),
    .open_q       (shutter_b_open_q)
  );

  logic wait_a_q, wait_b_q;
  logic filt_go;
  logic [7:0] filt_d;

  always_comb begin
    filt_go = 1'b0;
    filt_d  = cmd_byte_q;
    if (single && is_filt && !is_shut_a && !is_shut_b && !is_host && !is_batch) begin
      filt_go = 1'b1;
    end else if (phase_q == cmd_decoder_pkg::PH_FILT_A && slot_vld_q[2]) begin
      filt_go = 1'b1;
      filt_d  = slot_q[2];
    end else if (phase_q == cmd_decoder_pkg::PH_FILT_B && slot_vld_q[3]) begin
      filt_go = 1'b1;
      filt_d  = slot_q[3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      filt_stb_q  <= 1'b0;
      filt_byte_q <= 8'h00;
    end else begin
      filt_stb_q <= filt_go;
      if (filt_go) begin
        filt_byte_q <= filt_d;
      end
    end
  end

  // ****************************************
  // busy handshake
  // ****************************************
  logic [15:0] hold_cnt_q;
  logic        running;
  logic        ready;

  assign running = phase_q inside {cmd_decoder_pkg::PH_SHUT, cmd_decoder_pkg::PH_FILT_A,
                                   cmd_decoder_pkg::PH_FILT_B};
  assign ready   = !cmd_stb_q && !running && !filt_stb_q && hold_cnt_q == 16'h0000 &&
                   !(wait_a_q && wheel_a_moving) && !(wait_b_q && wheel_b_moving);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_cnt_q <= 16'h0000;
    end else if (cmd_stb_q || running) begin
      hold_cnt_q <= hold_cfg_q;
    end else if (hold_cnt_q != 16'h0000) begin
      hold_cnt_q <= hold_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wait_a_q <= 1'b0;
      wait_b_q <= 1'b0;
    end else if (filt_go) begin
      wait_a_q <= !filt_d[cmd_decoder_pkg::WHEEL_BIT] || wait_a_q;
      wait_b_q <= filt_d[cmd_decoder_pkg::WHEEL_BIT] || wait_b_q;
    end else if (!busy_q) begin
      wait_a_q <= 1'b0;
      wait_b_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (par_take || ser_take) begin
      busy_q <= 1'b1;
    end else if (busy_q && ready) begin
      busy_q <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  busy_on_take_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (par_take || ser_take) |=> busy_q ##1 busy_q)
    else $error("busy not raised for an accepted command");
  no_sample_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    busy_q |-> !par_take && !ser_take)
    else $error("inputs taken while busy");
  poll_change_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    par_take |-> poll_tick && par_cmd != prev_par_q)
    else $error("parallel input taken without a change on a poll");
  host_enter_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_stb_q && is_host && !host_mode_q |=> host_mode_q && src_serial_q == $past(cmd_src_q))
    else $error("host code did not enter host mode on its source");
  src_switch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_stb_q && is_host && host_mode_q && !from_active |=> $changed(src_serial_q))
    else $error("source not switched by host code on other input");
  batch_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_q == cmd_decoder_pkg::PH_COLLECT |=> !filt_stb_q)
    else $error("filter command issued while batch still collecting");
  batch_run_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    phase_q == cmd_decoder_pkg::PH_COLLECT ##1 phase_q == cmd_decoder_pkg::PH_SHUT
    |-> $past(batch_cnt_q) == 3'h3 ##3 phase_q == cmd_decoder_pkg::PH_IDLE && batch_cnt_q == 3'h0)
    else $error("batch did not run after four entries");
  // shutter modes must stay put; the open level may still follow a conditional wheel
  odd_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    single && !is_host && !is_batch && !is_shut_a && !is_shut_b && !is_filt
    |=> !filt_stb_q && phase_q == cmd_decoder_pkg::PH_IDLE && $stable(u_shut_a.mode_q) &&
        $stable(u_shut_b.mode_q) && (host_mode_q || $past(local_req || force_local)))
    else $error("unlisted code acted upon");

endmodule

// [bench/host_model.sv]
// host side model: drives the parallel command lines and paces itself on busy
`timescale 1ns/1ps
module host_model #(
  parameter int WAIT_MAX = 64
) (
  input  wire logic       core_clk,
  input  wire logic       busy_q,
  output logic [7:0]      par_cmd
);
  initial par_cmd = 8'h00;

  // ****************************************
  // busy handshake
  // ****************************************
  task automatic wait_handshake(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < WAIT_MAX && busy_q !== 1'b1; n++) @(posedge core_clk);
    if (busy_q === 1'b1) begin
      for (n = 0; n < 4096 && busy_q !== 1'b0; n++) @(posedge core_clk);
      ok = (busy_q === 1'b0);
    end
  endtask

  // returns after busy has risen and fallen again, or when busy has not risen within WAIT_MAX cycles
  task automatic send(input logic [7:0] v, output bit ok);
    @(posedge core_clk);
    par_cmd <= v;
    wait_handshake(ok);
  endtask
endmodule

// [bench/special_cmd_decoder_tb_top.sv]
// self-checking bench for the special command decoder
`timescale 1ns/1ps
module special_cmd_decoder_tb_top;
  localparam int POLL = 16;
  logic        core_clk, sys_rst, avs_read, avs_write, ser_stb, local_req, avs_waitrequest;
  logic        wheel_a_moving, wheel_b_moving, busy_q, host_mode_q, src_serial_q;
  logic        shutter_a_open_q, shutter_b_open_q, filt_stb_q, exp_host, exp_src, exp_a, exp_b;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  par_cmd, ser_cmd, filt_byte_q, v;
  logic [7:0]  got_q[$], exp_q[$];
  logic [7:0]  shut_tab[6] = '{8'hAA, 8'hBA, 8'hAC, 8'hBC, 8'hAB, 8'hBB};
  // row 0 out of order, filters and shutters interleaved; row 1 in the recommended order
  logic [7:0]  bat_tab[2][4] = '{'{8'h93, 8'hAC, 8'h25, 8'hBC}, '{8'hAA, 8'hBA, 8'h37, 8'hC5}};
  int          err_total, samples_checked, i, t0;
  bit          ok;

  special_cmd_decoder #(.POLL_CYCLES(POLL)) dut_u (.core_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .par_cmd,
    .ser_stb, .ser_cmd, .local_req, .wheel_a_moving, .wheel_b_moving, .busy_q,
    .host_mode_q, .src_serial_q, .shutter_a_open_q, .shutter_b_open_q, .filt_stb_q,
    .filt_byte_q);
  host_model #(.WAIT_MAX(3 * POLL)) hm_u (.core_clk, .busy_q, .par_cmd);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (filt_stb_q === 1'b1) got_q.push_back(filt_byte_q);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    for (n = 0; n < 16 && avs_waitrequest !== 1'b0; n++) @(posedge core_clk);
    if (n == 16) err_total++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic snd(input logic [7:0] b, input bit exp_ok);
    hm_u.send(b, ok);
    chk(32'(ok), 32'(exp_ok));
  endtask

  // one byte on the second input, then the busy handshake
  task automatic ser_send(input logic [7:0] b);
    @(posedge core_clk);
    ser_cmd <= b;
    ser_stb <= 1'b1;
    @(posedge core_clk);
    ser_stb <= 1'b0;
    hm_u.wait_handshake(ok);
    chk(32'(ok), 1);
  endtask

  // model state against the outputs, filter bytes in order
  task automatic cmp_model();
    repeat (3) @(posedge core_clk);
    chk(host_mode_q, exp_host);
    chk(src_serial_q, exp_src);
    chk(shutter_a_open_q, exp_a);
    chk(shutter_b_open_q, exp_b);
    chk(got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {sys_rst, avs_read, avs_write, ser_stb, local_req, wheel_a_moving, wheel_b_moving} = 7'h40;
    {avs_address, avs_writedata, ser_cmd} = '0;
    {exp_host, exp_src, exp_a, exp_b} = 4'h0;
    void'($urandom(59145));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk({busy_q, host_mode_q, shutter_a_open_q, shutter_b_open_q, filt_stb_q}, 0);
    av(0, 3'h1, 0);
    chk(rd, 0);
    av(0, 3'h0, 0);
    chk(rd, 1);
    av(0, 3'h3, 0);
    chk(rd, 32'(cmd_decoder_pkg::HOLD_RESET));
    av(1, 3'h5, 32'hFFFF);
    av(0, 3'h5, 0);
    chk(rd, 0);
    av(1, 3'h3, 32'h8);
    av(0, 3'h3, 0);
    chk(rd, 32'h8);
    v = {1'b1, 3'($urandom), 4'($urandom % 10)};
    snd(v, 1);
    cmp_model();
    snd(8'hEE, 1);
    exp_host = 1'b1;
    cmp_model();
    av(0, 3'h1, 0);
    chk(rd, 32'h1);
    foreach (shut_tab[k]) begin
      snd(shut_tab[k], 1);
      if (shut_tab[k][4]) exp_b = shut_tab[k][3:0] != 4'hC;
      else exp_a = shut_tab[k][3:0] != 4'hC;
      cmp_model();
    end
    for (i = 0; i < 2; i++) begin
      wheel_a_moving <= (i == 0);
      wheel_b_moving <= (i == 0);
      exp_a = 1'(i);
      exp_b = 1'(i);
      cmp_model();
    end
    for (i = 0; i < 4; i++) begin
      v = {1'($urandom), 3'($urandom), 4'($urandom % 10)};
      if (v == par_cmd) v[7] = ~v[7];
      snd(v, 1);
      exp_q.push_back(v);
      cmp_model();
    end
    snd(v, 0);
    cmp_model();
    snd(8'hAD, 1);
    snd(8'hEF, 1);
    cmp_model();
    for (int j = 0; j < 2; j++) begin
      t0 = int'($time);
      snd(8'hDF, 1);
      for (int k = 0; k < 4; k++) begin
        snd(bat_tab[j][k], 1);
        if (k == 3) begin
          {exp_a, exp_b} = j ? 2'h3 : 2'h0;
          exp_q.push_back(bat_tab[j][2]);
          exp_q.push_back(bat_tab[j][j ? 3 : 0]);
        end
        cmp_model();
      end
      chk(32'(int'($time) - t0 < 5000000), 1);
    end
    snd(8'hAC, 1);
    exp_a = 1'b0;
    cmp_model();
    // parallel holds AC, never EE, while serial sends EE
    ser_send(8'hEE);
    exp_src = 1'b1;
    cmp_model();
    snd(8'hAA, 1);
    cmp_model();
    // serial leaves EE before local mode is asked for
    ser_send(8'h11);
    exp_q.push_back(8'h11);
    cmp_model();
    local_req <= 1'b1;
    @(posedge core_clk);
    local_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(host_mode_q, 0);
    snd(8'hEE, 1);
    av(0, 3'h2, 0);
    chk(rd, 32'hEE);
    snd(8'h05, 1);
    exp_q.push_back(8'h05);
    {exp_host, exp_src} = 2'h2;
    cmp_model();
    av(1, 3'h0, 32'h3);
    av(0, 3'h1, 0);
    chk(rd, 32'h200);
    av(1, 3'h0, 32'h0);
    snd(8'h06, 0);
    exp_host = 1'b0;
    cmp_model();
    end_of_test();
  end
endmodule
